// ### bench/tvu_core_model.sv
// tvu_core_model: core side that takes traps and leaves them again
// assumes: same clock as the unit, trap_req is a level
`timescale 1ns/1ps
`default_nettype none
module tvu_core_model (
  input  wire logic       pclk,       // core clock
  input  wire logic       presetn,    // async reset, active low
  input  wire logic       trap_req,   // trap ready for the core
  input  wire logic       hold_done,  // keep the instruction busy
  input  wire logic [3:0] wait_cyc,   // service delay in cycles
  output logic            instr_done, // instruction complete
  output logic            trap_ack,   // take the trap
  output logic            trap_ret    // leave the trap
);
  logic       busy_q;
  logic [3:0] cnt_q;
  logic       due;
  assign due = (cnt_q == wait_cyc);
  // ack a waiting trap after wait_cyc cycles, return after as many again
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {instr_done, trap_ack, trap_ret, busy_q, cnt_q} <= '0;
    end else begin
      instr_done <= !hold_done;
      trap_ack   <= !busy_q && trap_req && due;
      trap_ret   <= busy_q && due;
      if (due && (busy_q || trap_req)) begin
        busy_q <= !busy_q;
        cnt_q  <= '0;
      end else if (busy_q || trap_req) begin
        cnt_q <= cnt_q + 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ### bench/tvu_top_tb_top.sv
// tvu_top_tb_top: self-checking bench for the trap and vector unit
// assumes: tvu_pkg compiled first, the core side is tvu_core_model
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin failures++; \
  $display("mismatch %s expected %0h seen %0h", nm, ex, got); end end
module tvu_top_tb_top import tvu_pkg::*; ;
  logic                 pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]           paddr, trap_vec, irq_vec;
  logic [31:0]          pwdata, prdata, rd;
  tvu_core_evt_s        core_ev;
  logic                 instr_done, trap_ack, trap_ret, wdt_timeout, goto_vld, osc_fail_pin;
  logic                 supply_dip_pin, hold_done, fetch_vld, div_abort, reset_req, trap_req, irq_req;
  logic [23:0]          goto_target, fetch_addr;
  logic [NUM_SRC-1:0]   src_req;
  logic [3*NUM_SRC-1:0] src_prio;
  logic [3:0]           trap_lvl, current_priority_level, wait_cyc;
  int                   failures, comparisons, resets, aborts, k;

  tvu_top i_dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
    .pslverr, .core_ev, .instr_done, .trap_ack, .trap_ret, .wdt_timeout, .goto_target, .goto_vld,
    .osc_fail_pin, .supply_dip_pin, .src_req, .src_prio, .trap_req, .trap_lvl, .trap_vec, .irq_req,
    .irq_vec, .current_priority_level, .fetch_addr, .fetch_vld, .div_abort, .reset_req);
  tvu_core_model i_core (.pclk, .presetn, .trap_req, .hold_done, .wait_cyc, .instr_done, .trap_ack,
    .trap_ret);

  // clock, reset request counter and watchdog
  initial begin
    pclk = 0;
    forever #4 pclk = ~pclk;
  end
  always @(posedge pclk) if (reset_req === 1'b1) resets++;
  always @(posedge pclk) if (div_abort === 1'b1) aborts++;
  initial begin
    repeat (20000) @(posedge pclk);
    failures++;
    wrap_up;
  end

  ////////////////////////////////////////////////////////////
  // apb transfer: setup, then access until pready
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 40);
    `CHK("pready", 1'b1, pready)
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task rchk(input logic [7:0] a, input logic [31:0] ex, input string nm);
    apb(0, a, 32'h0);
    `CHK(nm, ex, rd)
  endtask
  // requests at positions a and b with priorities pa and pb
  task irq(input int a, input int b, input logic [2:0] pa, input logic [2:0] pb, input logic [7:0] ev);
    logic [NUM_SRC-1:0] r;
    logic [3*NUM_SRC-1:0] p;
    r = '0; p = '0; r[a] = 1; r[b] = 1; p[3*a +: 3] = pa; p[3*b +: 3] = pb;
    @(posedge pclk);
    src_req <= r; src_prio <= p;
    repeat (3) @(posedge pclk);
    `CHK("irq_req", ev != 0, irq_req)
    if (ev != 0) `CHK("irq_vec", ev, irq_vec)
  endtask
  // one trap condition k held over two ticks while the instruction runs
  task trap(input int k, input logic [3:0] lvl);
    tvu_core_evt_s e;
    int n;
    int a;
    e = '0;
    e.div_zero = (k == 0);
    e.acc_ovf31 = {1'b0, k == 1};
    e.acc_ovf39 = {k == 2, 1'b0};
    e.shift_over = (k == 3);
    e.misalign = (k == 4);
    e.data_unimpl = (k == 5);
    e.prog_unimpl = (k == 6);
    e.vec_fetch = (k == 7);
    {e.multiply_accumulate_class, e.opp_space} = {2{k == 8}};
    e.lit_unimpl = (k == 9);
    e.pc_unimpl = (k == 10);
    e.vec_invalid = (k == 11);
    e.sp_load = (k == 12 || k == 13);
    e.sp_val = (k == 12) ? 16'h2000 : 16'h0400;
    hold_done <= 1; wait_cyc <= k[0] ? 4'h5 : 4'h0;
    repeat (2) @(posedge pclk);
    a = aborts;
    core_ev <= e; osc_fail_pin <= (k == 14);
    repeat (8) @(posedge pclk);
    core_ev <= '0; osc_fail_pin <= 0;
    #1 `CHK("trap_lvl", lvl, trap_lvl)
    `CHK("trap_vec", {4'h0, lvl - 4'h8}, trap_vec)
    `CHK("trap_req", 1'b0, trap_req)
    hold_done <= 0;
    for (n = 0; n < 40 && current_priority_level[3] !== 1'b1; n++) @(posedge pclk);
    `CHK("level_top", 4'hf, current_priority_level)
    for (n = 0; n < 40 && current_priority_level[3] !== 1'b0; n++) @(posedge pclk);
    `CHK("level_top", 4'h7, current_priority_level)
    `CHK("div_abort", k == 0, aborts != a)
  endtask
  // reset causes: k selects the event, ex the cause bits expected
  task cause(input int k, input logic [5:0] ex);
    tvu_core_evt_s e;
    int r;
    e = '0;
    e.opc_unused = (k < 2);
    e.opc_flushed = (k == 0);
    e.uninit_w = (k == 2);
    e.div_zero = (k == 3);
    e.misalign = (k == 3 || k == 7);
    apb(1, REG_CAUSE, 32'h3f);
    r = resets;
    core_ev <= e; wdt_timeout <= (k == 4); supply_dip_pin <= (k == 5);
    repeat (8) @(posedge pclk);
    core_ev <= '0; wdt_timeout <= 0; supply_dip_pin <= 0;
    apb(0, REG_CAUSE, 32'h0);
    `CHK("cause", ex, rd[5:0])
    `CHK("reset_req", ex != 0, resets != r)
  endtask
  task wrap_up;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    presetn = 0; {psel, penable, pwrite, goto_vld, wdt_timeout, hold_done} = '0;
    {osc_fail_pin, supply_dip_pin} = '0; paddr = '0; pwdata = '0; core_ev = '0;
    goto_target = '0; src_req = '0; src_prio = '0; wait_cyc = '0;
    repeat (12) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    #1 `CHK("fetch_vld", 1'b1, fetch_vld)
    `CHK("fetch_addr", RESET_VEC, fetch_addr)
    @(posedge pclk);
    goto_target <= 24'h000200; goto_vld <= 1;
    @(posedge pclk);
    goto_vld <= 0;
    #1 `CHK("fetch_vld", 1'b1, fetch_vld)
    `CHK("fetch_addr", 24'h000200, fetch_addr)
    rchk(REG_STKLIM, 32'h0000ffff, "stk_limit");
    rchk(REG_CTRL, 32'h0, "ctrl");
    rchk(8'h18, 32'h0, "unmapped");
    `CHK("pslverr", 1'b1, err)
    $display("test reset_entry done");
    irq(0, 0, 3'h3, 3'h3, 8'd8);
    irq(39, 39, 3'h2, 3'h2, 8'd47);
    irq(40, 40, 3'h2, 3'h2, 8'd48);
    irq(43, 43, 3'h2, 3'h2, 8'd51);
    irq(41, 44, 3'h7, 3'h7, 8'd0);
    irq(5, 3, 3'h4, 3'h4, 8'd11);
    irq(5, 3, 3'h6, 3'h2, 8'd13);
    apb(1, REG_CPL, 32'h7);
    irq(3, 3, 3'h7, 3'h7, 8'd0);
    src_req <= '0;
    $display("test vectors done");
    apb(1, REG_CTRL, 32'h3);
    apb(1, REG_STKLIM, 32'h1000);
    for (k = 0; k < 15; k++) trap(k, k < 4 ? LVL_MATH : k < 12 ? LVL_ADDR : k < 14 ? LVL_STK : LVL_OSC);
    $display("test traps done");
    cause(0, 6'h00);
    cause(1, 6'h04);
    cause(2, 6'h02);
    cause(4, 6'h01);
    cause(5, 6'h08);
    cause(3, 6'h10);
    // oscillator trap left pending, then a lower hard trap: conflict
    hold_done <= 1; osc_fail_pin <= 1;
    repeat (8) @(posedge pclk);
    osc_fail_pin <= 0;
    repeat (4) @(posedge pclk);
    cause(7, 6'h20);
    $display("test causes done");
    wrap_up;
  end
endmodule
`default_nettype wire

// ### common/tvu_pkg.sv
// tvu_pkg: constants, types and helpers for the trap and vector unit
// assumes: one 125 MHz clock, core events held for a whole instruction cycle
package tvu_pkg;
  // clock and instruction cycle
  localparam int         CLK_NS        = 8;
  localparam int         INSTR_NS      = 32;
  localparam int         CLK_PER_INSTR = (INSTR_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [1:0] DIV_LAST      = 2'(CLK_PER_INSTR - 1);
  localparam logic [1:0] DIV_ONE       = 2'h1;
  // peripheral sources
  localparam int          NUM_SRC          = 54;
  localparam logic [7:0]  VEC_OFS          = 8'h08;
  localparam int          SRC_PERIOD_MATCH = 39;
  localparam int          SRC_ENCODER      = 40;
  localparam int          SRC_FAULT_A      = 43;
  localparam logic [53:0] SRC_LOW_BLOCK    = 54'h000_0000_3ff_ffff;
  localparam logic [53:0] SRC_IMPL = SRC_LOW_BLOCK | (54'h1 << SRC_PERIOD_MATCH)
                                   | (54'h1 << SRC_ENCODER) | (54'h1 << SRC_FAULT_A);
  // trap classes and levels
  localparam int         TR_MATH = 0;
  localparam int         TR_ADDR = 1;
  localparam int         TR_STK  = 2;
  localparam int         TR_OSC  = 3;
  localparam logic [3:0] TRAP_HARD     = 4'he;
  localparam logic [3:0] LVL_NONE      = 4'h0;
  localparam logic [3:0] LVL_MATH      = 4'hb;
  localparam logic [3:0] LVL_ADDR      = 4'hc;
  localparam logic [3:0] LVL_STK       = 4'hd;
  localparam logic [3:0] LVL_OSC       = 4'he;
  localparam logic [3:0] TRAP_LVL_BASE = 4'h8;
  localparam logic [15:0] SP_FLOOR     = 16'h0800;
  localparam logic [15:0] STKLIM_RST   = 16'hffff;
  localparam logic [23:0] RESET_VEC    = 24'h000000;
  // register map
  localparam logic [7:0] REG_CTRL  = 8'h00;
  localparam logic [7:0] REG_STKLIM = 8'h04;
  localparam logic [7:0] REG_TRAP  = 8'h08;
  localparam logic [7:0] REG_CAUSE = 8'h0c;
  localparam logic [7:0] REG_CPL   = 8'h10;
  localparam logic [7:0] REG_IRQ   = 8'h14;
  localparam int CTRL_OVF31 = 0;
  localparam int CTRL_OVF39 = 1;
  // reset cause bits
  localparam int NUM_CAUSE  = 6;
  localparam int CS_WDT     = 0;
  localparam int CS_UNINITW = 1;
  localparam int CS_ILLEGAL = 2;
  localparam int CS_SUPPLY  = 3;
  localparam int CS_LOCKOUT = 4;
  localparam int CS_CONFLCT = 5;

  typedef enum logic [1:0] {BOOT_FETCH, BOOT_TARGET, BOOT_RUN} tvu_boot_e;

  typedef struct packed {
    logic        div_zero;
    logic [1:0]  acc_ovf31;
    logic        guard_used;
    logic [1:0]  acc_ovf39;
    logic        sat_on;
    logic        shift_over;
    logic        misalign;
    logic        data_unimpl;
    logic        multiply_accumulate_class;
    logic        opp_space;
    logic        prog_unimpl;
    logic        vec_fetch;
    logic        lit_unimpl;
    logic        pc_unimpl;
    logic        vec_invalid;
    logic        sp_load;
    logic [15:0] sp_val;
    logic        opc_unused;
    logic        opc_flushed;
    logic        uninit_w;
  } tvu_core_evt_s;

  // level of the highest set trap class
  function automatic logic [3:0] tvu_trap_top(input logic [3:0] p);
    tvu_trap_top = p[TR_OSC] ? LVL_OSC : p[TR_STK] ? LVL_STK :
                   p[TR_ADDR] ? LVL_ADDR : p[TR_MATH] ? LVL_MATH : LVL_NONE;
  endfunction

  // class bit that belongs to a level
  function automatic logic [3:0] tvu_lvl_bit(input logic [3:0] l);
    tvu_lvl_bit = (l == LVL_OSC) ? 4'h8 : (l == LVL_STK) ? 4'h4 :
                  (l == LVL_ADDR) ? 4'h2 : (l == LVL_MATH) ? 4'h1 : 4'h0;
  endfunction
endpackage

// ### verilog/tvu_src_rank.sv
// tvu_src_rank: picks the winning peripheral request
// assumes: requests already masked to implemented positions
`timescale 1ns/1ps
`default_nettype none
module tvu_src_rank import tvu_pkg::*; (
  input  wire logic [NUM_SRC-1:0]   req,   // pending requests
  input  wire logic [3*NUM_SRC-1:0] prio,  // three bits per source
  output logic                      found, // some request ranks above zero
  output logic [5:0]                num,   // winning interrupt number
  output logic [2:0]                lvl    // winning user priority
);
  // scan down so that a lower number wins a tie
  always_comb begin
    found = 1'b0;
    num   = 6'h00;
    lvl   = 3'h0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (req[i] && prio[3*i +: 3] != 3'h0 && prio[3*i +: 3] >= lvl) begin
        found = 1'b1;
        num   = 6'(i);
        lvl   = prio[3*i +: 3];
      end
    end
  end
endmodule
`default_nettype wire

// ### verilog/tvu_top.sv
// tvu_top: trap detection, trap ranking, request vectoring and reset entry
// assumes: APB master on pclk, core logic on pclk, pins asynchronous
`timescale 1ns/1ps
`default_nettype none
module tvu_top import tvu_pkg::*; (
  input  wire logic                   pclk,          // core clock
  input  wire logic                   presetn,       // async reset, active low
  input  wire logic [7:0]             paddr,         // APB address
  input  wire logic                   psel,          // APB select
  input  wire logic                   penable,       // APB enable
  input  wire logic                   pwrite,        // APB direction
  input  wire logic [31:0]            pwdata,        // APB write data
  output logic [31:0]                 prdata,        // APB read data
  output logic                        pready,        // APB ready
  output logic                        pslverr,       // APB error
  input  wire tvu_core_evt_s          core_ev,       // core fault events
  input  wire logic                   instr_done,    // faulting instruction complete
  input  wire logic                   trap_ack,      // core takes the trap
  input  wire logic                   trap_ret,      // core leaves the trap
  input  wire logic                   wdt_timeout,   // watchdog expiry
  input  wire logic [23:0]            goto_target,   // jump target at reset entry
  input  wire logic                   goto_vld,      // goto_target valid
  input  wire logic                   osc_fail_pin,  // clock monitor, async
  input  wire logic                   supply_dip_pin,// supply monitor, async
  input  wire logic [NUM_SRC-1:0]     src_req,       // peripheral requests
  input  wire logic [3*NUM_SRC-1:0]   src_prio,      // user priorities
  output logic                        trap_req,      // trap ready for the core
  output logic [3:0]                  trap_lvl,      // highest pending trap level
  output logic [7:0]                  trap_vec,      // its vector number
  output logic                        irq_req,       // interrupt for the core
  output logic [7:0]                  irq_vec,       // its vector number
  output logic [3:0]                  current_priority_level, // level incl top bit
  output logic [23:0]                 fetch_addr,    // reset entry fetch address
  output logic                        fetch_vld,     // fetch_addr valid
  output logic                        div_abort,     // abort divide at boundary
  output logic                        reset_req      // device reset request
);
  ////////////////////////////////////////////////////////////////////////
  logic [1:0]  div_q, div_d;
  logic        tick;
  logic [1:0]  osc_s_q, dip_s_q;
  logic [3:0]  cond, new_c, hard_new, pend_q, pend_d, ack_clr;
  logic [3:0]  lvl_act_q, top_pend, held_lvl, top_new;
  logic        illegal, uninit, conflict, lockout;
  logic [NUM_CAUSE-1:0] cause_q, cause_set, cause_clr;
  logic [1:0]  ctrl_q;
  logic [15:0] stk_limit_q;
  logic [2:0]  cpl_lo_q;
  logic        src_found;
  logic [5:0]  src_num;
  logic [2:0]  src_lvl;
  logic [NUM_SRC-1:0] req_impl;
  logic        setup, wr_en, hit;
  logic [31:0] rd_data;
  tvu_boot_e   boot_q;

  ////////////////////////////////////////////////////////////////////////
  // instruction cycle divider
  assign tick  = (div_q == DIV_LAST);
  assign div_d = tick ? 2'h0 : div_q + DIV_ONE;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) div_q <= 2'h0;
    else          div_q <= div_d;
  end

  // two-stage synchronisers for pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_s_q <= 2'h0;
      dip_s_q <= 2'h0;
    end else begin
      osc_s_q <= {osc_s_q[0], osc_fail_pin};
      dip_s_q <= {dip_s_q[0], supply_dip_pin};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  tvu_trap_detect u_detect (
    .ev      (core_ev),
    .ovf_en  (ctrl_q),
    .stk_limit (stk_limit_q),
    .cond    (cond),
    .illegal (illegal),
    .uninit  (uninit)
  );

  // trap conditions sampled once per instruction cycle
  assign new_c    = tick ? (cond | {osc_s_q[1], 3'h0}) : 4'h0;
  assign hard_new = new_c & TRAP_HARD;
  assign top_pend = tvu_trap_top(pend_q);
  assign top_new  = tvu_trap_top(hard_new);
  assign held_lvl = (top_pend > lvl_act_q) ? top_pend : lvl_act_q;
  assign conflict = (hard_new != 4'h0) && (top_new < held_lvl);
  assign lockout  = (new_c & (new_c - 4'h1)) != 4'h0;
  assign ack_clr  = trap_ack ? tvu_lvl_bit(top_pend) : 4'h0;
  // a new condition wins over the acknowledge clear
  assign pend_d   = (pend_q & ~ack_clr) | new_c;

  // pending traps and the one in service
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_q    <= 4'h0;
      lvl_act_q <= LVL_NONE;
    end else begin
      pend_q <= pend_d;
      if (trap_ack)      lvl_act_q <= top_pend;
      else if (trap_ret) lvl_act_q <= LVL_NONE;
    end
  end

  // trap presentation to the core
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trap_req <= 1'b0;
      trap_lvl <= LVL_NONE;
      trap_vec <= 8'h00;
    end else begin
      trap_lvl <= tvu_trap_top(pend_d);
      trap_vec <= {4'h0, tvu_trap_top(pend_d) - TRAP_LVL_BASE};
      trap_req <= (pend_d != 4'h0) & instr_done;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // peripheral requests, reserved positions masked off
  assign req_impl = src_req & SRC_IMPL;

  tvu_src_rank u_rank (
    .req   (req_impl),
    .prio  (src_prio),
    .found (src_found),
    .num   (src_num),
    .lvl   (src_lvl)
  );

  // maskable request only above the current level and with no trap
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_req <= 1'b0;
      irq_vec <= 8'h00;
    end else begin
      irq_req <= src_found && ({1'b0, src_lvl} > current_priority_level)
                 && (pend_d == 4'h0);
      irq_vec <= {2'h0, src_num} + VEC_OFS;
    end
  end

  // current level: top bit follows trap service
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      current_priority_level <= 4'h0;
    end else begin
      if (trap_ack)      current_priority_level[3] <= 1'b1;
      else if (trap_ret) current_priority_level[3] <= 1'b0;
      current_priority_level[2:0] <= cpl_lo_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // reset causes, kept apart from the arbitration path
  assign cause_set[CS_WDT]     = wdt_timeout;
  assign cause_set[CS_UNINITW] = tick & uninit;
  assign cause_set[CS_ILLEGAL] = tick & illegal;
  assign cause_set[CS_SUPPLY]  = dip_s_q[1];
  assign cause_set[CS_LOCKOUT] = lockout;
  assign cause_set[CS_CONFLCT] = conflict;
  assign cause_clr = (wr_en && paddr == REG_CAUSE) ? pwdata[NUM_CAUSE-1:0] : '0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cause_q   <= '0;
      reset_req <= 1'b0;
      div_abort <= 1'b0;
    end else begin
      cause_q   <= (cause_q & ~cause_clr) | cause_set;
      reset_req <= |cause_set;
      div_abort <= tick & core_ev.div_zero;
    end
  end

  // reset entry: fetch at zero, then at the jump target
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_q     <= BOOT_FETCH;
      fetch_addr <= RESET_VEC;
      fetch_vld  <= 1'b0;
    end else begin
      case (boot_q)
        BOOT_FETCH: begin
          fetch_addr <= RESET_VEC;
          fetch_vld  <= 1'b1;
          boot_q     <= BOOT_TARGET;
        end
        BOOT_TARGET: begin
          fetch_vld <= 1'b0;
          if (goto_vld) begin
            fetch_addr <= goto_target;
            fetch_vld  <= 1'b1;
            boot_q     <= BOOT_RUN;
          end
        end
        BOOT_RUN: fetch_vld <= 1'b0;
        default:  boot_q <= BOOT_FETCH;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // APB decode, no wait states, pready in the first access cycle
  assign setup = psel & ~penable;
  assign wr_en = psel & penable & pwrite & pready;
  assign hit   = (paddr == REG_CTRL) | (paddr == REG_STKLIM) | (paddr == REG_TRAP)
               | (paddr == REG_CAUSE) | (paddr == REG_CPL) | (paddr == REG_IRQ);
  assign rd_data = (paddr == REG_CTRL)  ? {30'h0, ctrl_q} :
                   (paddr == REG_STKLIM) ? {16'h0, stk_limit_q} :
                   (paddr == REG_TRAP)  ? {20'h0, lvl_act_q, trap_lvl, pend_q} :
                   (paddr == REG_CAUSE) ? {26'h0, cause_q} :
                   (paddr == REG_CPL)   ? {28'h0, current_priority_level} :
                   (paddr == REG_IRQ)   ? {15'h0, irq_req, irq_vec, 2'h0, src_num} : 32'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~hit;
      prdata  <= (setup & ~pwrite) ? rd_data : 32'h0;
    end
  end

  // software registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q   <= 2'h0;
      stk_limit_q <= STKLIM_RST;
      cpl_lo_q <= 3'h0;
    end else if (wr_en) begin
      if (paddr == REG_CTRL)  ctrl_q   <= pwdata[1:0];
      if (paddr == REG_STKLIM) stk_limit_q <= pwdata[15:0];
      if (paddr == REG_CPL)   cpl_lo_q <= pwdata[2:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  chk_trap_top_bit: assert property (@(posedge pclk) disable iff (!presetn)
    trap_ack |=> current_priority_level[3])
    else $error("top level bit not set in trap");
  chk_lvl_seven_block: assert property (@(posedge pclk) disable iff (!presetn)
    current_priority_level == 4'h7 |=> !irq_req)
    else $error("request above level seven");
  chk_reserved_none: assert property (@(posedge pclk) disable iff (!presetn)
    irq_req |-> (irq_vec - VEC_OFS) inside {[8'd0:8'd25], 8'd39, 8'd40, 8'd43})
    else $error("reserved vector requested");
  chk_vec_offset: assert property (@(posedge pclk) disable iff (!presetn)
    irq_req |-> irq_vec >= VEC_OFS)
    else $error("vector below offset");
  chk_stack_floor: assert property (@(posedge pclk) disable iff (!presetn)
    tick && core_ev.sp_load && core_ev.sp_val < SP_FLOOR |=> pend_q[TR_STK])
    else $error("stack floor not trapped");
  chk_lockout_reset: assert property (@(posedge pclk) disable iff (!presetn)
    tick && cond[TR_MATH] && cond[TR_ADDR] |=> reset_req ##0 cause_q[CS_LOCKOUT])
    else $error("lockout did not reset");
  chk_trap_wait: assert property (@(posedge pclk) disable iff (!presetn)
    trap_req |-> $past(instr_done))
    else $error("trap before completion");
  chk_flush_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    tick && core_ev.opc_flushed && !core_ev.uninit_w && !wdt_timeout && !dip_s_q[1]
    && cond == 4'h0 |=> !reset_req)
    else $error("flushed opcode caused reset");
  chk_boot_zero: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(fetch_vld) && boot_q == BOOT_TARGET |-> fetch_addr == RESET_VEC)
    else $error("first fetch not at zero");
  chk_level_same: assert property (@(posedge pclk) disable iff (!presetn)
    tick && cond[TR_ADDR] && pend_q == 4'h0 && !trap_ack |=> trap_lvl >= LVL_ADDR)
    else $error("trap level late");

  // trap class, level and blocking checks
  chk_div_abort: assert property (@(posedge pclk) disable iff (!presetn)
    tick && core_ev.div_zero |=> div_abort && pend_q[TR_MATH])
    else $error("divide by zero not aborted");
  chk_stack_limit: assert property (@(posedge pclk) disable iff (!presetn)
    tick && core_ev.sp_load && core_ev.sp_val > stk_limit_q |=> pend_q[TR_STK])
    else $error("stack limit not trapped");
  chk_osc_level: assert property (@(posedge pclk) disable iff (!presetn)
    pend_q[TR_OSC] |-> trap_lvl == LVL_OSC)
    else $error("oscillator trap level wrong");
  chk_trap_blocks_irq: assert property (@(posedge pclk) disable iff (!presetn)
    pend_q != 4'h0 |-> !irq_req)
    else $error("request while trap pending");

  // reset cause checks
  chk_conflict_cause: assert property (@(posedge pclk) disable iff (!presetn)
    conflict |=> reset_req && cause_q[CS_CONFLCT])
    else $error("hard conflict did not reset");
  chk_wdt_cause: assert property (@(posedge pclk) disable iff (!presetn)
    wdt_timeout |=> reset_req && cause_q[CS_WDT])
    else $error("watchdog did not reset");
  chk_illegal_cause: assert property (@(posedge pclk) disable iff (!presetn)
    tick && core_ev.opc_unused && !core_ev.opc_flushed |=> reset_req && cause_q[CS_ILLEGAL])
    else $error("illegal opcode did not reset");

  // reset entry and cover points
  chk_fetch_target: assert property (@(posedge pclk) disable iff (!presetn)
    boot_q == BOOT_TARGET && goto_vld |=> fetch_vld && fetch_addr == $past(goto_target))
    else $error("jump target not fetched");
  cov_trap_taken:  cover property (@(posedge pclk) disable iff (!presetn) trap_req ##1 trap_ack);
  cov_irq_raised:  cover property (@(posedge pclk) disable iff (!presetn) $rose(irq_req));
  cov_conflict:    cover property (@(posedge pclk) disable iff (!presetn) conflict);
  cov_lockout:     cover property (@(posedge pclk) disable iff (!presetn) lockout);
  cov_boot_target: cover property (@(posedge pclk) disable iff (!presetn) boot_q == BOOT_TARGET && goto_vld);
endmodule
`default_nettype wire

// ### verilog/tvu_trap_detect.sv
// tvu_trap_detect: turns core events into trap classes and reset causes
// assumes: events come from core logic on the same clock
`timescale 1ns/1ps
`default_nettype none
module tvu_trap_detect import tvu_pkg::*; (
  input  wire tvu_core_evt_s ev,        // core events this cycle
  input  wire logic [1:0]    ovf_en,    // overflow trap enables
  input  wire logic [15:0]   stk_limit, // stack limit value
  output logic [3:0]         cond,      // trap classes raised
  output logic               illegal,   // executed unused opcode
  output logic               uninit     // uninitialised pointer use
);
  logic math_c;
  logic addr_c;
  logic stk_c;

  // math error sources
  assign math_c = ev.div_zero
                | (ovf_en[CTRL_OVF31] & (|ev.acc_ovf31) & ~ev.guard_used)
                | (ovf_en[CTRL_OVF39] & (|ev.acc_ovf39) & ~ev.sat_on)
                | ev.shift_over;
  // address error sources
  assign addr_c = ev.misalign | ev.data_unimpl | ev.prog_unimpl | ev.vec_fetch
                | (ev.multiply_accumulate_class & ev.opp_space)
                | ev.lit_unimpl | ev.pc_unimpl
                | ev.vec_invalid;
  // stack error on load above limit or below floor
  assign stk_c = ev.sp_load & ((ev.sp_val > stk_limit)
                             | (ev.sp_val < SP_FLOOR));
  assign cond    = {1'b0, stk_c, addr_c, math_c};
  assign illegal = ev.opc_unused & ~ev.opc_flushed;
  assign uninit  = ev.uninit_w;
endmodule
`default_nettype wire
